/* File: rtl/zcb_pkg.sv */
// Purpose: shared constants and types for the zero-compare branch unit
// Assumes: 32-bit instruction words, 64-bit registers and addresses
// Notes:   field positions and encodings live here only
package zcb_pkg;
  localparam int XLEN      = 64;
  localparam int ILEN      = 32;
  localparam int OP_HI     = 31;
  localparam int OP_LO     = 26;
  localparam int RS_HI     = 25;
  localparam int RS_LO     = 21;
  localparam int SEL_HI    = 20;
  localparam int SEL_LO    = 16;
  localparam int IMM_HI    = 15;
  localparam int IMM_LO    = 0;
  localparam int IMM_W     = 16;
  localparam int DISP_W    = 18;
  localparam int SHIFT_W   = 2;
  localparam int REG_W     = 5;

  localparam logic [5:0] OPC_GT_ZERO        = 6'h07;
  localparam logic [5:0] OPC_GT_ZERO_LIKELY = 6'h17;
  localparam logic [5:0] OPC_LE_ZERO        = 6'h06;
  localparam logic [5:0] OPC_LE_ZERO_LIKELY = 6'h16;
  localparam logic [5:0] OPC_REG_IMM_CLASS  = 6'h01;

  localparam logic [4:0] SEL_ZERO_FIELD     = 5'h00;
  localparam logic [4:0] SEL_LT_ZERO        = 5'h00;
  localparam logic [4:0] SEL_LT_ZERO_LINK   = 5'h10;
  localparam logic [4:0] SEL_LT_ZERO_LINK_L = 5'h12;

  localparam logic [4:0]      LINK_REG      = 5'h1F;
  localparam logic [XLEN-1:0] LINK_STEP     = 64'h0000_0000_0000_0008;
  localparam logic [XLEN-1:0] SLOT_STEP     = 64'h0000_0000_0000_0004;

  typedef enum logic [1:0] {
    ZCB_IDLE  = 2'b00,
    ZCB_SLOT  = 2'b01
  } zcb_state_t;

  typedef enum logic [1:0] {
    ZCB_CMP_GT = 2'b00,
    ZCB_CMP_LE = 2'b01,
    ZCB_CMP_LT = 2'b10
  } zcb_cmp_t;
endpackage

/* File: rtl/zcb_dec_if.sv */
// Purpose: decode results passed from decoder to the execute core
// Assumes: single clock, same domain
// Notes:   none
interface zcb_dec_if;
  import zcb_pkg::*;
  logic                    is_branch;
  logic                    likely;
  logic                    link;
  zcb_cmp_t                cmp;
  logic [XLEN-1:0]         disp;
  logic [REG_W-1:0]        src_reg;
  modport dec (output is_branch, likely, link, cmp, disp, src_reg);
  modport exe (input  is_branch, likely, link, cmp, disp, src_reg);
endinterface

/* File: rtl/zcb_decoder.sv */
// Purpose: combinational decode of the zero-compare branch family
// Assumes: instruction word valid when sampled by the caller
// Notes:   unrecognised words give is_branch low
module zcb_decoder
  import zcb_pkg::*;
(
  input  wire logic [ILEN-1:0] instr_i,
  zcb_dec_if.dec               dec
);
  wire logic [5:0]       opc      = instr_i[OP_HI:OP_LO];
  wire logic [4:0]       sel      = instr_i[SEL_HI:SEL_LO];
  wire logic [IMM_W-1:0] imm      = instr_i[IMM_HI:IMM_LO];
  wire logic             sel_zero = (sel == SEL_ZERO_FIELD);
  // gt/le forms need a zero second register field
  wire logic gt_any = sel_zero && (opc == OPC_GT_ZERO ||
                                   opc == OPC_GT_ZERO_LIKELY); // [RQ3]
  wire logic le_any = sel_zero && (opc == OPC_LE_ZERO ||
                                   opc == OPC_LE_ZERO_LIKELY); // [RQ4]
  wire logic rim    = (opc == OPC_REG_IMM_CLASS);
  wire logic lt_pl  = rim && (sel == SEL_LT_ZERO);              // [RQ5]
  wire logic lt_lk  = rim && (sel == SEL_LT_ZERO_LINK);         // [RQ5]
  wire logic lt_lkl = rim && (sel == SEL_LT_ZERO_LINK_L);       // [RQ5]
  wire logic [DISP_W-1:0] disp18 = {imm, {SHIFT_W{1'b0}}};      // [RQ1]

  assign dec.is_branch = gt_any | le_any | lt_pl | lt_lk | lt_lkl;
  assign dec.likely    = opc == OPC_GT_ZERO_LIKELY ||
                         opc == OPC_LE_ZERO_LIKELY || lt_lkl;
  assign dec.link      = lt_lk | lt_lkl;
  assign dec.cmp       = gt_any ? ZCB_CMP_GT :
                         le_any ? ZCB_CMP_LE : ZCB_CMP_LT;
  assign dec.disp      = {{(XLEN-DISP_W){disp18[DISP_W-1]}}, disp18}; // [RQ1]
  assign dec.src_reg   = instr_i[RS_HI:RS_LO];
endmodule

/* File: rtl/zcb_unit.sv */
// Purpose: execute the zero-compare branches and their delay slots
// Assumes: one instruction offered per issue pulse, in program order
// Notes:   the slot after a branch is tracked by a two-state machine
//
// Functional notes
// RQ1 - displacement is offset with two zero bits, sign-extended to 64
// RQ2 - target is delay-slot address plus displacement
// RQ3 - opcodes 000111 and 010111 decode as greater-than-zero forms
// RQ4 - opcodes 000110 and 010110 decode as less-or-equal-zero forms
// RQ5 - register-immediate class selects lt, lt link, lt link likely
// RQ6 - greater-than-zero: sign clear and value nonzero
// RQ7 - less-or-equal-zero: sign set or value zero
// RQ8 - less-than-zero: sign bit set
// RQ9 - redirect pc after the delay slot completes
// RQ10 - likely not taken squashes the delay slot
// RQ11 - link forms always write register 31
// RQ12 - link value is branch address plus eight
// RQ13 - software must not test register 31 in link forms
// RQ14 - exception in delay slot reports the branch as restart
// RQ15 - non-likely forms always execute the delay slot
// RQ16 - these branches raise no exception themselves
module zcb_unit
  import zcb_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 issue_i,
  input  wire logic [ILEN-1:0]      instr_i,
  input  wire logic [XLEN-1:0]      pc_i,
  input  wire logic [XLEN-1:0]      src_val_i,
  input  wire logic                 slot_exc_i,
  output logic                      is_branch_o,
  output logic [REG_W-1:0]          src_reg_o,
  output logic                      link_we_o,
  output logic [REG_W-1:0]          link_reg_o,
  output logic [XLEN-1:0]           link_val_o,
  output logic                      redirect_o,
  output logic [XLEN-1:0]           target_o,
  output logic                      squash_delay_slot_o,
  output logic                      exc_o,
  output logic [XLEN-1:0]           epc_o,
  output logic                      in_slot_o
);
  zcb_dec_if dif();

  zcb_decoder u_dec (
    .instr_i (instr_i),
    .dec     (dif.dec)
  );

  zcb_state_t state;
  zcb_state_t next_state;
  logic       taken_q;
  logic       likely_q;
  logic [XLEN-1:0] target_q;
  logic [XLEN-1:0] branch_pc_q;

  wire logic sign    = src_val_i[XLEN-1];
  wire logic is_zero = (src_val_i == '0);
  wire logic cond_gt = !sign && !is_zero;                      // [RQ6]
  wire logic cond_le = sign || is_zero;                        // [RQ7]
  wire logic cond_lt = sign;                                   // [RQ8]
  wire logic cond    = (dif.cmp == ZCB_CMP_GT) ? cond_gt :
                       (dif.cmp == ZCB_CMP_LE) ? cond_le : cond_lt;
  // a branch in the slot of another branch is not accepted as one
  wire logic br_now  = issue_i && dif.is_branch && state == ZCB_IDLE;
  wire logic slot_go = issue_i && state == ZCB_SLOT;
  wire logic [XLEN-1:0] slot_pc = pc_i + SLOT_STEP;
  wire logic [XLEN-1:0] tgt     = slot_pc + dif.disp;          // [RQ2]
  wire logic [XLEN-1:0] link_v  = pc_i + LINK_STEP;            // [RQ12]
  wire logic slot_squash = slot_go && likely_q && !taken_q;    // [RQ10]
  // redirect only when slot retires without fault; likely-false has none
  wire logic slot_redir  = slot_go && taken_q && !slot_exc_i;  // [RQ9]
  wire logic slot_fault  = slot_go && slot_exc_i && !slot_squash; // [RQ14]

  // helper state for the slot checks below: it keeps the outcome of
  // an accepted branch across any number of idle cycles before its slot
  wire logic [XLEN-1:0] chk_disp = {{(XLEN-DISP_W){instr_i[IMM_HI]}},
                                    instr_i[IMM_HI:IMM_LO],
                                    {SHIFT_W{1'b0}}};
  logic            chk_taken_q;
  logic            chk_void_q;
  logic [XLEN-1:0] chk_tgt_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      chk_taken_q <= 1'b0;
      chk_void_q  <= 1'b0;
      chk_tgt_q   <= '0;
    end else if (br_now) begin
      chk_taken_q <= cond;
      chk_void_q  <= dif.likely && !cond;
      chk_tgt_q   <= pc_i + SLOT_STEP + chk_disp;
    end else if (issue_i) begin
      chk_taken_q <= 1'b0;
      chk_void_q  <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ZCB_IDLE: begin
        if (br_now) begin
          next_state = ZCB_SLOT;
        end
      end
      ZCB_SLOT: begin
        if (slot_go) begin
          next_state = ZCB_IDLE;
        end
      end
      default: begin
        next_state = ZCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state       <= ZCB_IDLE;
      taken_q     <= 1'b0;
      likely_q    <= 1'b0;
      target_q    <= '0;
      branch_pc_q <= '0;
    end else begin
      state <= next_state;
      if (br_now) begin
        taken_q     <= cond;
        likely_q    <= dif.likely;
        target_q    <= tgt;
        branch_pc_q <= pc_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      is_branch_o         <= 1'b0;
      src_reg_o           <= '0;
      link_we_o           <= 1'b0;
      link_reg_o          <= '0;
      link_val_o          <= '0;
      redirect_o          <= 1'b0;
      target_o            <= '0;
      squash_delay_slot_o <= 1'b0;
      exc_o               <= 1'b0;
      epc_o               <= '0;
      in_slot_o           <= 1'b0;
    end else begin
      is_branch_o         <= br_now;
      src_reg_o           <= dif.src_reg;
      link_we_o           <= br_now && dif.link;               // [RQ11]
      link_reg_o          <= LINK_REG;                         // [RQ11]
      link_val_o          <= link_v;                           // [RQ12]
      redirect_o          <= slot_redir;                       // [RQ9]
      target_o            <= target_q;
      squash_delay_slot_o <= slot_squash;                      // [RQ10]
      // the branch itself never faults; only its slot may
      exc_o               <= slot_fault;                       // [RQ16]
      epc_o               <= branch_pc_q;                      // [RQ14]
      in_slot_o           <= state == ZCB_SLOT;
    end
  end

  // non-likely slot always runs: never squashed
  a_plain_slot_runs : assert property (@(posedge sys_clk_i) // [RQ15]
    disable iff (sys_rst_i)
    slot_go && !likely_q |=> !squash_delay_slot_o)
    else $error("non-likely slot squashed");

  a_link_always : assert property (@(posedge sys_clk_i) // [RQ11]
    disable iff (sys_rst_i)
    br_now && dif.link |=> link_we_o && link_val_o ==
      $past(pc_i) + LINK_STEP)
    else $error("link write missing or wrong");

  a_link_reg_fixed : assert property (@(posedge sys_clk_i) // [RQ11]
    disable iff (sys_rst_i)
    link_we_o |-> link_reg_o == LINK_REG)
    else $error("link written to wrong register");

  a_plain_no_link : assert property (@(posedge sys_clk_i) // [RQ11]
    disable iff (sys_rst_i)
    br_now && !dif.link |=> !link_we_o)
    else $error("link write from a plain branch");

  a_gt_cond : assert property (@(posedge sys_clk_i) // [RQ6]
    disable iff (sys_rst_i)
    br_now && dif.cmp == ZCB_CMP_GT |=>
      taken_q == ($past(src_val_i) != '0 &&
                  !$past(src_val_i[XLEN-1])))
    else $error("gt condition wrong");

  a_le_cond : assert property (@(posedge sys_clk_i) // [RQ7]
    disable iff (sys_rst_i)
    br_now && dif.cmp == ZCB_CMP_LE |=>
      taken_q == ($past(src_val_i) == '0 ||
                  $past(src_val_i[XLEN-1])))
    else $error("le condition wrong");

  a_lt_cond : assert property (@(posedge sys_clk_i) // [RQ8]
    disable iff (sys_rst_i)
    br_now && dif.cmp == ZCB_CMP_LT |=>
      taken_q == $past(src_val_i[XLEN-1]))
    else $error("lt condition wrong");

  a_branch_flag_set : assert property (@(posedge sys_clk_i) // [RQ3]
    disable iff (sys_rst_i)
    br_now |=> is_branch_o)
    else $error("accepted branch not flagged");

  a_foreign_no_flag : assert property (@(posedge sys_clk_i) // [RQ5]
    disable iff (sys_rst_i)
    issue_i && !dif.is_branch |=> !is_branch_o)
    else $error("foreign word flagged as branch");

  // a branch word offered as a delay slot is run as a plain slot
  a_nested_slot_plain : assert property (@(posedge sys_clk_i) // [RQ9]
    disable iff (sys_rst_i)
    slot_go |=> !is_branch_o && in_slot_o)
    else $error("branch in slot accepted as branch");

  a_slot_ends_wait : assert property (@(posedge sys_clk_i) // [RQ9]
    disable iff (sys_rst_i)
    slot_go |=> state == ZCB_IDLE)
    else $error("slot issue did not end the wait");

  sequence s_taken_pending;
    chk_taken_q;
  endsequence

  sequence s_void_pending;
    chk_void_q;
  endsequence

  sequence s_slot_clean;
    issue_i && !slot_exc_i;
  endsequence

  sequence s_slot_fault;
    issue_i && slot_exc_i;
  endsequence

  // the slot may follow after idle cycles; the helper flag spans them
  a_redirect_after : assert property (@(posedge sys_clk_i) // [RQ9]
    disable iff (sys_rst_i)
    s_taken_pending ##0 s_slot_clean |=> redirect_o)
    else $error("taken branch not redirected after slot");

  a_target_out : assert property (@(posedge sys_clk_i) // [RQ2]
    disable iff (sys_rst_i)
    s_taken_pending ##0 s_slot_clean |=>
      target_o == $past(chk_tgt_q))
    else $error("redirect target wrong");

  a_fault_no_redirect : assert property (@(posedge sys_clk_i) // [RQ14]
    disable iff (sys_rst_i)
    s_taken_pending ##0 s_slot_fault |=> exc_o && !redirect_o)
    else $error("faulting slot still redirected");

  a_no_early_redirect : assert property (@(posedge sys_clk_i) // [RQ9]
    disable iff (sys_rst_i)
    br_now |=> !redirect_o)
    else $error("redirect before slot");

  a_target_calc : assert property (@(posedge sys_clk_i) // [RQ1]
    disable iff (sys_rst_i)
    br_now |=> target_q == $past(pc_i) + SLOT_STEP +
      {{(XLEN-DISP_W){$past(instr_i[IMM_HI])}},
       $past(instr_i[IMM_HI:IMM_LO]), 2'b00})
    else $error("branch target wrong");

  a_squash_likely : assert property (@(posedge sys_clk_i) // [RQ10]
    disable iff (sys_rst_i)
    s_void_pending ##0 issue_i |=> squash_delay_slot_o && !redirect_o)
    else $error("likely slot not squashed");

  // a squashed slot has no effect, so its fault is dropped as well
  a_void_no_exc : assert property (@(posedge sys_clk_i) // [RQ10]
    disable iff (sys_rst_i)
    s_void_pending ##0 s_slot_fault |=> !exc_o)
    else $error("squashed slot raised a fault");

  a_pulses_exclusive : assert property (@(posedge sys_clk_i) // [RQ9]
    disable iff (sys_rst_i)
    redirect_o |-> !squash_delay_slot_o && !exc_o)
    else $error("redirect together with squash or fault");

  a_exc_from_slot : assert property (@(posedge sys_clk_i) // [RQ16]
    disable iff (sys_rst_i)
    exc_o |-> $past(slot_go))
    else $error("fault raised outside a delay slot");

  a_idle_quiet : assert property (@(posedge sys_clk_i) // [RQ16]
    disable iff (sys_rst_i)
    state == ZCB_IDLE |=>
      !redirect_o && !squash_delay_slot_o && !exc_o)
    else $error("slot pulse without a pending slot");

  a_slot_epc : assert property (@(posedge sys_clk_i) // [RQ14]
    disable iff (sys_rst_i)
    slot_fault |=> exc_o && epc_o == $past(branch_pc_q))
    else $error("slot fault restart point wrong");
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for the zero-compare branch unit
// Assumes: fixed latencies of one cycle after branch and after slot issue
// Notes:   assertions live in the design; this bench only compares values
module tb;
  import zcb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic            sys_clk_i;
  logic            sys_rst_i;
  logic            issue_i;
  logic [ILEN-1:0] instr_i;
  logic [XLEN-1:0] pc_i;
  logic [XLEN-1:0] src_val_i;
  logic            slot_exc_i;
  logic            is_branch_o;
  logic [REG_W-1:0] src_reg_o;
  logic            link_we_o;
  logic [REG_W-1:0] link_reg_o;
  logic [XLEN-1:0] link_val_o;
  logic            redirect_o;
  logic [XLEN-1:0] target_o;
  logic            squash_delay_slot_o;
  logic            exc_o;
  logic [XLEN-1:0] epc_o;
  logic            in_slot_o;
  int              errors;
  int              check_count;

  // one row per form: opcode, selector, compare kind, likely, link
  localparam logic [5:0] F_OP [7] = '{OPC_GT_ZERO, OPC_GT_ZERO_LIKELY,
    OPC_LE_ZERO, OPC_LE_ZERO_LIKELY, OPC_REG_IMM_CLASS, OPC_REG_IMM_CLASS,
    OPC_REG_IMM_CLASS};
  localparam logic [4:0] F_SEL [7] = '{SEL_ZERO_FIELD, SEL_ZERO_FIELD,
    SEL_ZERO_FIELD, SEL_ZERO_FIELD, SEL_LT_ZERO, SEL_LT_ZERO_LINK,
    SEL_LT_ZERO_LINK_L};
  localparam zcb_cmp_t F_CMP [7] = '{ZCB_CMP_GT, ZCB_CMP_GT, ZCB_CMP_LE,
    ZCB_CMP_LE, ZCB_CMP_LT, ZCB_CMP_LT, ZCB_CMP_LT};
  localparam logic F_LK [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic F_LN [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  // boundary values around zero and both extremes of the signed range
  localparam logic [XLEN-1:0] VALS [5] = '{64'h0, 64'h1,
    64'h7FFF_FFFF_FFFF_FFFF, 64'h8000_0000_0000_0000, 64'hFFFF_FFFF_FFFF_FFFF};

  zcb_unit u_zcb_unit (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .issue_i(issue_i), .instr_i(instr_i), .pc_i(pc_i),
    .src_val_i(src_val_i), .slot_exc_i(slot_exc_i),
    .is_branch_o(is_branch_o), .src_reg_o(src_reg_o),
    .link_we_o(link_we_o), .link_reg_o(link_reg_o),
    .link_val_o(link_val_o), .redirect_o(redirect_o), .target_o(target_o),
    .squash_delay_slot_o(squash_delay_slot_o), .exc_o(exc_o),
    .epc_o(epc_o), .in_slot_o(in_slot_o));

  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic cond(zcb_cmp_t c, logic [63:0] v);
    case (c)
      ZCB_CMP_GT: return !v[63] && (v != 64'h0);
      ZCB_CMP_LE: return v[63] || (v == 64'h0);
      default:    return v[63];
    endcase
  endfunction

  // issue a branch, then its slot, and judge both answers
  task automatic do_branch(input int f, input logic [15:0] imm,
      input logic [63:0] pc, input logic [63:0] v, input logic fault);
    logic [63:0] disp;
    logic        tk;
    disp = {{46{imm[15]}}, imm, 2'b00};
    tk   = cond(F_CMP[f], v);
    @(posedge sys_clk_i); #1;
    issue_i    = 1'b1;
    instr_i    = {F_OP[f], 5'h0B, F_SEL[f], imm};
    pc_i       = pc;
    src_val_i  = v;
    slot_exc_i = 1'b0;
    @(posedge sys_clk_i); #1;
    check("is_branch", {63'h0, is_branch_o}, 64'h1);
    check("src_reg", {59'h0, src_reg_o}, 64'h0B);
    check("in_slot", {63'h0, in_slot_o}, 64'h0);
    check("link_we", {63'h0, link_we_o}, {63'h0, F_LN[f]});
    if (F_LN[f]) begin
      check("link_reg", {59'h0, link_reg_o}, 64'h1F);
      check("link_val", link_val_o, pc + 64'h8);
    end
    instr_i    = 32'h0000_0000;
    pc_i       = pc + 64'h4;
    src_val_i  = ~v;
    slot_exc_i = fault;
    @(posedge sys_clk_i); #1;
    issue_i    = 1'b0;
    slot_exc_i = 1'b0;
    check("redirect", {63'h0, redirect_o}, {63'h0, tk && !fault});
    check("squash", {63'h0, squash_delay_slot_o},
          {63'h0, F_LK[f] && !tk});
    check("exc", {63'h0, exc_o},
          {63'h0, fault && !(F_LK[f] && !tk)});
    check("in_slot_held", {63'h0, in_slot_o}, 64'h1);
    if (tk && !fault) begin
      check("target", target_o, pc + 64'h4 + disp);
    end
    if (fault && !(F_LK[f] && !tk)) check("epc", epc_o, pc);
  endtask

  // every form against every boundary value, both offset signs
  task automatic sc_forms();
    for (int f = 0; f < 7; f++) begin
      for (int i = 0; i < 5; i++) begin
        do_branch(f, (i % 2) ? 16'h8000 : 16'h7FFF,
                  64'h0000_0001_0000_1000 + 64'(i * 16), VALS[i], 1'b0);
      end
    end
  endtask

  // a fault in the slot must hold the redirect and name the branch
  task automatic sc_slot_fault();
    do_branch(0, 16'h0010, 64'h0000_0000_0040_0000, 64'h5, 1'b1);
    do_branch(6, 16'hFFF0, 64'h0000_0000_0040_0100, 64'h5, 1'b1);
    do_branch(5, 16'h0020, 64'h0000_0000_FFFF_FFF8, 64'h8000_0000_0000_0000,
              1'b1);
  endtask

  // idle cycles before the slot, and a branch word offered as the slot
  task automatic sc_gap_slot();
    @(posedge sys_clk_i); #1;
    issue_i    = 1'b1;
    instr_i    = {OPC_GT_ZERO, 5'h03, SEL_ZERO_FIELD, 16'h0008};
    pc_i       = 64'h0000_0000_0000_2000;
    src_val_i  = 64'h1;
    slot_exc_i = 1'b0;
    @(posedge sys_clk_i); #1;
    issue_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    check("gap_in_slot", {63'h0, in_slot_o}, 64'h1);
    check("gap_redirect", {63'h0, redirect_o}, 64'h0);
    issue_i   = 1'b1;
    pc_i      = 64'h0000_0000_0000_2004;
    src_val_i = 64'h0;
    @(posedge sys_clk_i); #1;
    issue_i = 1'b0;
    check("nested_branch", {63'h0, is_branch_o}, 64'h0);
    check("slot_redirect", {63'h0, redirect_o}, 64'h1);
    check("gap_target", target_o, 64'h0000_0000_0000_2024);
  endtask

  // a nonzero second field and a foreign opcode must not decode
  task automatic sc_ignored();
    @(posedge sys_clk_i); #1;
    issue_i   = 1'b1;
    instr_i   = {OPC_GT_ZERO, 5'h02, 5'h01, 16'h0004};
    src_val_i = 64'h1;
    @(posedge sys_clk_i); #1;
    check("bad_field", {63'h0, is_branch_o}, 64'h0);
    instr_i = {6'h23, 5'h02, 5'h00, 16'h0004};
    @(posedge sys_clk_i); #1;
    issue_i = 1'b0;
    check("foreign_op", {63'h0, is_branch_o}, 64'h0);
    @(posedge sys_clk_i); #1;
    check("no_redirect", {63'h0, redirect_o}, 64'h0);
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    stop_test();
  end

  initial begin
    errors      = 0;
    check_count = 0;
    sys_rst_i   = 1'b1;
    issue_i     = 1'b0;
    instr_i     = 32'h0;
    pc_i        = 64'h0;
    src_val_i   = 64'h0;
    slot_exc_i  = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    check("reset_branch", {63'h0, is_branch_o}, 64'h0);
    sc_forms();
    sc_slot_fault();
    sc_gap_slot();
    sc_ignored();
    stop_test();
  end
endmodule
